// ===== design/sfr_slave.sv
// FIFO and two-wire slave with its storage array.
`timescale 1ns/1ps

// ==========================================================================
// Write buffer with valid/ready on both sides.
module sfr_fifo
  import sfr_pkg::*;
#(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned DEPTH = 16
)
(
  input  wire logic             clk,       // System clock.
  input  wire logic             rst_b,     // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] in_data,   // Entry written.
  input  wire logic             in_valid,  // Entry offered.
  output logic                  in_ready,  // Room for an entry.
  output logic      [WIDTH-1:0] out_data,  // Oldest entry.
  output logic                  out_valid, // Oldest entry present.
  input  wire logic             out_ready  // Drain takes the entry.
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;

  assign in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[PW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem_q[wr_q[PW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // sfr_fifo

// ==========================================================================
// Two-wire slave, address latch and array.
module sfr_slave
  import sfr_pkg::*;
(
  input  wire logic       clk,                // System clock, 200 MHz.
  input  wire logic       rst_b,              // Synchronous reset, active low.
  input  wire logic       scl_in,             // Serial clock pin level.
  input  wire logic       sda_in,             // Serial data pin level.
  output logic            sda_out,            // Serial data drive value, always low.
  output logic            sda_oe,             // High while pulling data low.
  input  wire logic [2:0] chip_select_straps, // Select straps, pulled down.
  input  wire logic       write_lock          // Array write lock, pulled down.
);
  // ========================================================================
  // Pin synchronisers. Undriven straps and lock arrive as low via pull-down.
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] straps_s;
  logic       lock_s;

  always_ff @(posedge clk)
  begin
    pin_s1_q <= {write_lock, chip_select_straps, sda_in, scl_in};
    pin_s2_q <= pin_s1_q;
  end

  assign scl_s    = pin_s2_q[0];
  assign sda_s    = pin_s2_q[1];
  assign straps_s = pin_s2_q[4:2];
  assign lock_s   = pin_s2_q[5];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl_s && !scl_prev_q;
  assign scl_fall   = !scl_s && scl_prev_q;
  assign start_cond = scl_s && scl_prev_q && !sda_s && sda_prev_q;
  assign stop_cond  = scl_s && scl_prev_q && sda_s && !sda_prev_q;

  // ========================================================================
  // Array with a registered read of the current address.
  logic [DATA_BITS-1:0] array_q [ARRAY_WORDS];
  logic [ADDR_BITS-1:0] addr_q;
  logic [DATA_BITS-1:0] rd_data_q;

  always_ff @(posedge clk)
  begin
    rd_data_q <= array_q[addr_q];
  end

  // ========================================================================
  // Write buffer and the commit port, paced by an enable divider.
  sfr_wr_type wr_in;
  sfr_wr_type wr_out;
  logic       wr_push;
  logic       wr_room;
  logic       wr_pending;
  logic [1:0] div_q;
  logic       commit_en;

  assign commit_en = (div_q == COMMIT_DIV);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      div_q <= '0;
    else
      div_q <= div_q + 2'h1;
  end

  sfr_fifo #(
    .WIDTH ($bits(sfr_wr_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (wr_in),
    .in_valid  (wr_push),
    .in_ready  (wr_room),
    .out_data  (wr_out),
    .out_valid (wr_pending),
    .out_ready (commit_en)
  );

  always_ff @(posedge clk)
  begin
    if (wr_pending && commit_en)
      array_q[wr_out.addr] <= wr_out.data;
  end

  // ========================================================================
  // Bus protocol engine.
  sfr_state_type        state_q;
  sfr_byte_type         kind_q;
  logic [3:0]           cnt_q;
  logic [7:0]           sh_q;
  logic [4:0]           addr_hi_q;
  logic                 read_q;
  logic                 mack_q;
  logic                 oe_q;
  logic                 sel_match;

  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;
  assign sel_match = (sh_q[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE)
                  && (sh_q[SEL_MSB:SEL_LSB] == straps_s);

  // The byte just received: decide acknowledge, store and commit.
  assign wr_in.addr = addr_q;
  assign wr_in.data = sh_q;
  assign wr_push = (state_q == ST_RX) && scl_fall && (cnt_q == BITS_PER_BYTE)
                && (kind_q == BY_DATA) && !lock_s;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      kind_q  <= BY_DEV;
      cnt_q   <= '0;
      sh_q    <= '0;
      read_q  <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
    end
    else if (start_cond)
    begin
      state_q <= ST_RX;
      kind_q  <= BY_DEV;
      cnt_q   <= '0;
      oe_q    <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE: oe_q <= 1'b0;
        ST_RX:
        begin
          if (scl_rise && (cnt_q != BITS_PER_BYTE))
          begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scl_fall && (cnt_q == BITS_PER_BYTE))
          begin
            state_q <= ST_ACK;
            oe_q    <= 1'b1;
            if (kind_q == BY_DEV)
            begin
              read_q <= sh_q[RW_BIT];
              if (!sel_match)
              begin
                state_q <= ST_IDLE;
                oe_q    <= 1'b0;
              end
            end
            else if ((kind_q == BY_DATA) && !lock_s && !wr_room)
            begin
              state_q <= ST_IDLE;
              oe_q    <= 1'b0;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_q <= '0;
            if (read_q && (kind_q == BY_DEV))
            begin
              state_q <= ST_TX;
              sh_q    <= rd_data_q;
              oe_q    <= !rd_data_q[7];
            end
            else
            begin
              state_q <= ST_RX;
              oe_q    <= 1'b0;
              unique case (kind_q)
                BY_DEV:  kind_q <= BY_ADRH;
                BY_ADRH: kind_q <= BY_ADRL;
                BY_ADRL: kind_q <= BY_DATA;
                BY_DATA: kind_q <= BY_DATA;
              endcase
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_q == LAST_TX_BIT)
            begin
              state_q <= ST_MACK;
              oe_q    <= 1'b0;
            end
            else
            begin
              sh_q  <= {sh_q[6:0], 1'b0};
              oe_q  <= !sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            mack_q <= !sda_s;
          else if (scl_fall)
          begin
            cnt_q <= '0;
            if (mack_q)
            begin
              state_q <= ST_TX;
              sh_q    <= rd_data_q;
              oe_q    <= !rd_data_q[7];
            end
            else
            begin
              state_q <= ST_IDLE;
              oe_q    <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Address latch: no reset, loaded by address bytes, bumped per data byte.
  logic load_lo;
  logic bump;

  assign load_lo = (state_q == ST_RX) && scl_fall && (cnt_q == BITS_PER_BYTE)
                && (kind_q == BY_ADRL);
  assign bump = wr_push
             || ((state_q == ST_RX) && scl_fall && (cnt_q == BITS_PER_BYTE)
                 && (kind_q == BY_DATA) && lock_s)
             || (scl_fall && (state_q == ST_ACK) && read_q && (kind_q == BY_DEV))
             || (scl_fall && (state_q == ST_MACK) && mack_q);

  always_ff @(posedge clk)
  begin
    if ((state_q == ST_RX) && scl_fall && (cnt_q == BITS_PER_BYTE)
        && (kind_q == BY_ADRH))
      addr_hi_q <= sh_q[4:0];
  end

  always_ff @(posedge clk)
  begin
    if (load_lo)
      addr_q <= {addr_hi_q, sh_q};
    else if (bump)
      addr_q <= addr_q + 13'h0001;
  end
endmodule // sfr_slave

// ===== design/sfr_pkg.sv
// Package of constants and carrier types for the two-wire ferroelectric memory slave.
// ==========================================================================
// Function
// - 8,192 byte locations, each individually addressable.
// - Take 16-bit address, decode low 13 bits.
// - Answer only when straps match address select bits.
// - Unconnected chip-select strap reads as low.
// - Data line only pulled low or released.
// - Drive after clock falls, sample on rise.
// - Lock input high blocks all array writes.
// - Unconnected lock input reads low, writes enabled.
// - Commit after byte, no busy, always ready; the slave NACKs a data byte while the write buffer is full.
// - Slave byte: type, select bits, read flag.
// - Two address bytes high first; increment, wrap.
// - Send bytes while master acknowledges; NACK ends.
// - Write after eighth bit; earlier start/stop cancels.
package sfr_pkg;

  // ========================================================================
  // Array geometry.
  localparam int unsigned ARRAY_WORDS = 8192;
  localparam int unsigned ADDR_BITS   = 13;
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned FIFO_DEPTH  = 16;

  // ========================================================================
  // Slave byte layout and device type; the type code value is arbitrary.
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
  localparam int unsigned TYPE_MSB     = 7;
  localparam int unsigned TYPE_LSB     = 4;
  localparam int unsigned SEL_MSB      = 3;
  localparam int unsigned SEL_LSB      = 1;
  localparam int unsigned RW_BIT       = 0;

  // ========================================================================
  // Timing: bit counts and the commit-port enable divider.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;
  localparam logic [1:0] COMMIT_DIV    = 2'h3;
  localparam logic [2:0] SYNC_RESET    = 3'h7;

  // ========================================================================
  // Types.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } sfr_state_type;

  typedef enum logic [3:0] {
    BY_DEV  = 4'h1,
    BY_ADRH = 4'h2,
    BY_ADRL = 4'h4,
    BY_DATA = 4'h8
  } sfr_byte_type;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } sfr_wr_type;

endpackage

// ===== test/sfr_monitor.sv
// Port checker for the two-wire memory slave.
`timescale 1ns/1ps

module sfr_monitor
  import sfr_pkg::*;
(
  input wire logic       clk,                // Clock.
  input wire logic       rst_b,              // Reset.
  input wire logic       scl_in,             // Serial clock.
  input wire logic       sda_in,             // Serial data.
  input wire logic       sda_out,            // Drive value.
  input wire logic       sda_oe,             // Pull enable.
  input wire logic [2:0] chip_select_straps, // Straps.
  input wire logic       write_lock          // Lock.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic       scl_q;
  logic       sda_q;
  logic [3:0] n_q;
  logic [7:0] sh_q;
  logic       miss;

  // ==========================================================================
  // Slave byte decode: n_q is 0 before any start, 9 once the byte is in.
  assign miss = sh_q[7:4] != DEV_TYPE_CODE || sh_q[3:1] != chip_select_straps;

  always_ff @(posedge clk)
  begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      n_q <= 4'h0;
    else if (scl_q && scl_in && sda_q && !sda_in)
      n_q <= 4'h1;
    else if (scl_in && !scl_q && n_q != 4'h0 && n_q < 4'h9)
      n_q <= n_q + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (scl_in && !scl_q && n_q != 4'h0 && n_q < 4'h9)
      sh_q <= {sh_q[6:0], sda_in};
  end

  // ==========================================================================
  // Properties.
  property p_low_only;
    sda_out == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("data drive value not low");

  property p_fall_side;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_fall_side: assert property (p_fall_side)
    else $error("data drive changed with clock high");

  property p_after_fall;
    $changed(sda_oe) |-> $past(scl_in, 5);
  endproperty
  a_after_fall: assert property (p_after_fall)
    else $error("data drive changed late after clock fall");

  property p_stand;
    $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_stand: assert property (p_stand)
    else $error("data drive pulse too short");

  property p_idle;
    n_q == 4'h0 |-> !sda_oe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("drive before first start");

  property p_listen;
    n_q != 4'h0 && n_q < 4'h9 |-> !sda_oe;
  endproperty
  a_listen: assert property (p_listen)
    else $error("drive during slave byte");

  property p_refuse;
    n_q == 4'h9 && miss |-> !sda_oe;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("answer to foreign slave byte");

  property p_answer;
    $rose(n_q == 4'h9) && !miss |-> ##[1:16] sda_oe;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no acknowledge of own slave byte");

  cover property (n_q == 4'h9 && miss);
  cover property ($rose(sda_oe) && sh_q[0]);
  cover property ($rose(sda_oe) && !sh_q[0]);
endmodule // sfr_monitor

bind sfr_slave sfr_monitor u_monitor (
  .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_straps(chip_select_straps), .write_lock(write_lock)
);

// ===== test/sfr_master.sv
// Two-wire bus master model.
`timescale 1ns/1ps

module sfr_master
(
  input  wire logic clk,    // Clock.
  input  wire logic sda,    // Resolved data.
  output logic      scl,    // Serial clock.
  output logic      sda_rel // Low pulls data low.
);
  initial {scl, sda_rel} = 2'b11;

  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  task automatic start();
    sda_rel <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic stop();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b1;
    half();
  endtask

  // Data changes two cycles after the clock falls, so no false start is seen.
  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h1FF;
    for (int i = 8; i > 8 - n; i--)
    begin
      sda_rel <= tx[i];
      repeat (6) @(posedge clk);
      scl <= 1'b1;
      half();
      rx[i] = sda;
      scl <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // sfr_master

// ===== test/sfr_slave_tb.sv
// Testbench for the two-wire memory slave.
`timescale 1ns/1ps

module sfr_slave_tb
  import sfr_pkg::*;
;
  logic       clk;
  logic       rst_b;
  logic [2:0] straps;
  logic       write_lock;
  logic       scl;
  logic       sda_rel;
  logic       sda_out;
  logic       sda_oe;
  logic       sda;
  logic [8:0] r;
  int         fails;
  int         check_count;

  assign sda = sda_rel & !(sda_oe && !sda_out);

  sfr_master u_master (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  sfr_slave DUT (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_straps(straps), .write_lock(write_lock)
  );

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic ack);
    u_master.xfer({b, 1'b1}, 9, r);
    check("ack", {7'h00, !ack}, {7'h00, r[0]});
  endtask

  task automatic rb(input logic [7:0] e, input logic more);
    u_master.xfer({8'hFF, !more}, 9, r);
    check("data", e, r[8:1]);
  endtask

  task automatic sb(input logic rw);
    u_master.start();
    wb({DEV_TYPE_CODE, straps, rw}, 1'b1);
  endtask

  task automatic addr(input logic [15:0] a);
    sb(1'b0);
    wb(a[15:8], 1'b1);
    wb(a[7:0], 1'b1);
  endtask

  task automatic t_wrap();
    straps <= 3'h5;
    addr(16'hFFFE);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b1);
    addr(16'h1FFE);
    sb(1'b1);
    rb(8'h11, 1'b1);
    rb(8'h22, 1'b1);
    rb(8'h33, 1'b0);
    u_master.stop();
  endtask

  task automatic t_select();
    for (int s = 0; s < 8; s++)
    begin
      straps <= 3'(s);
      u_master.start();
      wb({DEV_TYPE_CODE, 3'(s) ^ 3'h2, 1'b0}, 1'b0);
      u_master.start();
      wb({DEV_TYPE_CODE ^ 4'h8, 3'(s), 1'b1}, 1'b0);
      sb(1'b0);
      u_master.stop();
    end
  endtask

  task automatic t_lock();
    straps <= 3'h0;
    addr(16'h0010);
    wb(8'h5A, 1'b1);
    u_master.stop();
    write_lock <= 1'b1;
    addr(16'h0010);
    wb(8'hA5, 1'b1);
    u_master.stop();
    write_lock <= 1'b0;
    addr(16'h0010);
    sb(1'b1);
    rb(8'h5A, 1'b0);
    u_master.stop();
  endtask

  task automatic t_abort();
    addr(16'h0020);
    wb(8'h77, 1'b1);
    wb(8'h66, 1'b1);
    addr(16'h0021);
    u_master.xfer(9'h133, 7, r);
    addr(16'h0020);
    sb(1'b1);
    rb(8'h77, 1'b1);
    rb(8'h66, 1'b0);
    u_master.stop();
  endtask

  task automatic complete_run();
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst_b = 1'b0;
    straps = 3'h0;
    write_lock = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_wrap();
    t_select();
    t_lock();
    t_abort();
    complete_run();
  end
endmodule // sfr_slave_tb
